// ### rmf_rmii_mac.sv
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module rmf_rmii_mac (
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  linkRefClock,
	input  wire logic                  carrierAndRxValid,
	input  wire logic [1:0]            rxDibit,
	input  wire logic                  rxSymbolError,
	output logic      [1:0]            txDibit,
	output logic                       txDibitValid,
	output logic                       mgmtPinsEnable,
	input  wire rmf_pkg::rmf_tx_beat_t txBeat,
	input  wire logic                  txBeatValid,
	output logic                       txBeatReady,
	output rmf_pkg::rmf_rx_beat_t      rxBeat,
	output logic                       rxBeatValid
);
	import rmf_pkg::*;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// Registers
	logic [5:0]    ctrl_reg;
	logic [31:0]   macLo_reg;
	logic [15:0]   macHi_reg;
	logic [15:0]   maxLen_reg;
	logic          collision_reg;
	logic          badLen_reg;
	logic          badCrc_reg;
	logic [31:0]   readMux;

	// Link sampling
	logic [2:0]    refSync;
	logic [1:0]    crsSync;
	logic [1:0]    errSync;
	logic [1:0]    dibSync0;
	logic [1:0]    dibSync1;
	logic [3:0]    divCnt_reg;

	// Transmit
	rmf_tx_state_t txState_reg;
	rmf_tx_state_t loadState;
	rmf_tx_beat_t  hold_reg;
	logic          holdValid_reg;
	logic [7:0]    txShift_reg;
	logic [7:0]    loadByte;
	logic [1:0]    txDibIdx_reg;
	logic [3:0]    preCnt_reg;
	logic [1:0]    fcsIdx_reg;
	logic [10:0]   txCnt_reg;
	logic          txEnded_reg;
	logic          txErr_reg;
	logic          consume;
	logic [31:0]   txCrc;

	// Receive
	rmf_rx_state_t rxState_reg;
	logic [15:0]   rxHunt_reg;
	logic [7:0]    rxSh_reg;
	logic [1:0]    rxDibIdx_reg;
	logic [15:0]   rxCnt_reg;
	logic          rxBad_reg;
	logic          rxAccept_reg;
	logic          rxGood_reg;
	logic [2:0]    flushCnt_reg;
	logic [7:0]    dly [0:5];
	logic [5:0]    destHit;
	logic [5:0]    bcHit;
	logic [31:0]   rxCrc;

	// APB decode
	wire apbWait   = psel & penable & ~pready;
	wire apbWrite  = psel & penable & pready & pwrite;
	wire hitCtrl   = paddr == ADDR_CTRL;
	wire hitMacLo  = paddr == ADDR_MAC_LO;
	wire hitMacHi  = paddr == ADDR_MAC_HI;
	wire hitMaxLen = paddr == ADDR_MAX_LEN;
	wire hitStatus = paddr == ADDR_STATUS;
	wire mapped    = hitCtrl | hitMacLo | hitMacHi | hitMaxLen | hitStatus;
	wire linkOn    = ctrl_reg[CTRL_RMII];
	wire speed100  = ctrl_reg[CTRL_SPEED100];
	wire keepFcs   = ctrl_reg[CTRL_KEEP_FCS];
	wire [47:0] macAddr = {macHi_reg, macLo_reg};

	// Sampled link
	wire refRise = refSync[1] & ~refSync[2];
	wire refFall = ~refSync[1] & refSync[2];
	wire slowLast = divCnt_reg == SLOW_DIV_LAST;
	wire txTick  = refRise & (speed100 | slowLast);
	wire rxTick  = refFall & (speed100 | (divCnt_reg == 4'h0));
	wire crs     = crsSync[1];
	wire rxErr   = errSync[1];
	wire [1:0] rxDib = dibSync1;

	// Transmit control
	wire txActive  = txState_reg != TX_IDLE;
	wire txStart   = txTick & ~txActive & holdValid_reg & linkOn;
	wire txLoad    = txTick & txActive & (txDibIdx_reg == 2'h3);
	wire txInSrc   = (txCnt_reg >= 11'(ADDR_LEN)) && (txCnt_reg < 11'(2 * ADDR_LEN));
	wire txContent = txState_reg == TX_SFD || txState_reg == TX_DATA;
	wire txUnder   = txContent & ~txInSrc & ~txEnded_reg & ~holdValid_reg;
	wire txPadMore = txCnt_reg < 11'(MIN_CONTENT_LEN);
	wire [2:0] srcIdx = 3'(txCnt_reg - 11'(ADDR_LEN));
	wire [7:0] srcByte = macAddr[{srcIdx, 3'b000} +: 8];
	wire [1:0] fcsSel = (txState_reg == TX_FCS) ? fcsIdx_reg + 2'h1 : 2'h0;
	wire [7:0] fcsByte = txCrc[{fcsSel, 3'b000} +: 8] ^ {8{~(txErr_reg | txUnder)}};
	wire txCrcEn   = txLoad & (loadState == TX_DATA || loadState == TX_PAD);
	wire consumeNow = txLoad & consume;
	wire holdNext  = (txBeatValid & txBeatReady) | (holdValid_reg & ~consumeNow);

	// Receive control
	wire [15:0] huntNext = {rxDib, rxHunt_reg[15:2]};
	wire [7:0]  rxByteNow = {rxDib, rxSh_reg[7:2]};
	wire rxSample  = rxTick & crs & linkOn;
	wire sfdSeen   = rxSample & (rxState_reg == RX_HUNT) & (huntNext == {SFD_BYTE, PREAMBLE_BYTE});
	wire rxPush    = rxSample & (rxState_reg == RX_FRAME) & (rxDibIdx_reg == 2'h3);
	wire rxEnd     = (rxState_reg == RX_FRAME) & ((rxTick & ~crs) | ~linkOn);
	wire addrOk    = ctrl_reg[CTRL_PROMISC] | (&destHit) | (ctrl_reg[CTRL_BCAST] & (&bcHit))
		| (ctrl_reg[CTRL_MCAST] & dly[5][0]);
	wire atDecide  = rxCnt_reg == 16'(ADDR_LEN);
	wire rxEmit    = rxPush & (rxCnt_reg >= 16'(ADDR_LEN)) & (atDecide ? addrOk : rxAccept_reg);
	wire lenOk     = (rxCnt_reg >= 16'(MIN_FRAME_LEN)) & (rxCnt_reg <= maxLen_reg);
	wire crcOk     = rxCrc == CRC_RESIDUE;
	wire flushing  = rxState_reg == RX_FLUSH;
	wire flushLast = flushing & (flushCnt_reg == 3'h1);
	wire collSet   = sfdSeen & txActive;
	wire collClr   = apbWrite & hitStatus & pwdata[ST_COLLISION];

	assign readMux = hitCtrl ? {26'h0, ctrl_reg}
		: hitMacLo ? macLo_reg
		: hitMacHi ? {16'h0, macHi_reg}
		: hitMaxLen ? {16'h0, maxLen_reg}
		: hitStatus ? {27'h0, badCrc_reg, badLen_reg, ~rxState_reg[0], txActive, collision_reg}
		: 32'h0;

	// Address compare per byte
	for (genvar i = 0; i < ADDR_LEN; i++) begin : g_addr
		assign destHit[i] = dly[ADDR_LEN - 1 - i] == macAddr[8 * i +: 8];
		assign bcHit[i]   = dly[i] == BCAST_BYTE;
	end

	// Delay line holds the last six bytes
	for (genvar i = 1; i < ADDR_LEN; i++) begin : g_dly
		always_ff @(posedge core_clk) begin
			if (reset)
				dly[i] <= 8'h00;
			else if (rxPush | flushing)
				dly[i] <= dly[i - 1];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			dly[0] <= 8'h00;
		else if (rxPush | flushing)
			dly[0] <= rxPush ? rxByteNow : 8'h00;
	end

	// APB slave, one wait state
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= apbWait;
			prdata  <= apbWait ? readMux : 32'h0;
			pslverr <= apbWait & ~mapped;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_reg   <= CTRL_RESET;
			macLo_reg  <= MAC_LO_RESET;
			macHi_reg  <= MAC_HI_RESET;
			maxLen_reg <= MAX_LEN_RESET;
		end else if (apbWrite) begin
			if (hitCtrl)
				ctrl_reg <= pwdata[5:0];
			if (hitMacLo)
				macLo_reg <= pwdata;
			if (hitMacHi)
				macHi_reg <= pwdata[15:0];
			if (hitMaxLen)
				maxLen_reg <= pwdata[15:0];
		end
	end

	// Status; a new collision beats the clear
	always_ff @(posedge core_clk) begin
		if (reset) begin
			collision_reg  <= 1'b0;
			mgmtPinsEnable <= 1'b0;
		end else begin
			collision_reg  <= collSet | (collision_reg & ~collClr);
			mgmtPinsEnable <= ~linkOn;
		end
	end

	// Synchronisers and reference clock divider
	always_ff @(posedge core_clk) begin
		if (reset) begin
			refSync  <= 3'h0;
			crsSync  <= 2'h0;
			errSync  <= 2'h0;
			dibSync0 <= 2'h0;
			dibSync1 <= 2'h0;
		end else begin
			refSync  <= {refSync[1:0], linkRefClock};
			crsSync  <= {crsSync[0], carrierAndRxValid};
			errSync  <= {errSync[0], rxSymbolError};
			dibSync0 <= rxDibit;
			dibSync1 <= dibSync0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			divCnt_reg <= 4'h0;
		else if (refRise)
			divCnt_reg <= (speed100 | slowLast) ? 4'h0 : divCnt_reg + 4'h1;
	end

	// Next byte to send
	always_comb begin
		loadState = txState_reg;
		loadByte  = PAD_BYTE;
		consume   = 1'b0;
		unique case (txState_reg)
			TX_IDLE: loadState = TX_IDLE;
			TX_PRE: begin
				loadState = (preCnt_reg == 4'(PREAMBLE_LEN)) ? TX_SFD : TX_PRE;
				loadByte  = (preCnt_reg == 4'(PREAMBLE_LEN)) ? SFD_BYTE : PREAMBLE_BYTE;
			end
			TX_SFD, TX_DATA: begin
				if (txInSrc) begin
					loadState = TX_DATA;
					loadByte  = srcByte;
				end else if (!txEnded_reg && holdValid_reg) begin
					loadState = TX_DATA;
					loadByte  = hold_reg.data;
					consume   = 1'b1;
				end else if (txPadMore) begin
					loadState = TX_PAD;
				end else begin
					loadState = TX_FCS;
					loadByte  = fcsByte;
				end
			end
			TX_PAD: begin
				loadState = txPadMore ? TX_PAD : TX_FCS;
				loadByte  = txPadMore ? PAD_BYTE : fcsByte;
			end
			TX_FCS: begin
				loadState = (fcsIdx_reg == 2'(FCS_LEN - 1)) ? TX_IDLE : TX_FCS;
				loadByte  = fcsByte;
			end
			default: loadState = TX_IDLE;
		endcase
	end

	// Transmit holding register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			hold_reg      <= '0;
			holdValid_reg <= 1'b0;
			txBeatReady   <= 1'b0;
		end else begin
			if (txBeatValid & txBeatReady)
				hold_reg <= txBeat;
			holdValid_reg <= holdNext;
			txBeatReady   <= ~holdNext;
		end
	end

	// Transmit sequencer, advances on reference edges
	always_ff @(posedge core_clk) begin
		if (reset) begin
			txState_reg  <= TX_IDLE;
			txShift_reg  <= 8'h00;
			txDibIdx_reg <= 2'h0;
			preCnt_reg   <= 4'h0;
			fcsIdx_reg   <= 2'h0;
			txCnt_reg    <= 11'h000;
			txEnded_reg  <= 1'b0;
			txErr_reg    <= 1'b0;
		end else if (txStart) begin
			txState_reg  <= TX_PRE;
			txShift_reg  <= PREAMBLE_BYTE;
			txDibIdx_reg <= 2'h0;
			preCnt_reg   <= 4'h1;
			fcsIdx_reg   <= 2'h0;
			txCnt_reg    <= 11'h000;
			txEnded_reg  <= 1'b0;
			txErr_reg    <= 1'b0;
		end else if (!linkOn) begin
			txState_reg <= TX_IDLE;
		end else if (txTick & txActive) begin
			txDibIdx_reg <= txDibIdx_reg + 2'h1;
			txShift_reg  <= txLoad ? loadByte : {2'h0, txShift_reg[7:2]};
			if (txLoad) begin
				txState_reg <= loadState;
				preCnt_reg  <= preCnt_reg + 4'h1;
				if (txCrcEn)
					txCnt_reg <= txCnt_reg + 11'h001;
				if (txState_reg == TX_FCS)
					fcsIdx_reg <= fcsIdx_reg + 2'h1;
				if (consume)
					txEnded_reg <= hold_reg.last;
				txErr_reg <= txErr_reg | txUnder | (consume & hold_reg.err);
			end
		end
	end

	// Pin drive, on reference edges or while the link is off
	always_ff @(posedge core_clk) begin
		if (reset) begin
			txDibitValid <= 1'b0;
			txDibit      <= 2'h0;
		end else if (txTick | ~linkOn) begin
			txDibitValid <= txActive & linkOn;
			txDibit      <= (txActive & linkOn) ? txShift_reg[1:0] : 2'h0;
		end
	end

	rmf_crc32 u_txCrc (
		.core_clk (core_clk),
		.reset    (reset),
		.init     (txStart),
		.enable   (txCrcEn),
		.dataByte (loadByte),
		.crc      (txCrc)
	);

	// Receive framing
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rxState_reg  <= RX_HUNT;
			rxHunt_reg   <= 16'h0;
			rxSh_reg     <= 8'h00;
			rxDibIdx_reg <= 2'h0;
			rxCnt_reg    <= 16'h0;
			rxBad_reg    <= 1'b0;
			rxAccept_reg <= 1'b0;
			rxGood_reg   <= 1'b0;
			flushCnt_reg <= 3'h0;
			badLen_reg   <= 1'b0;
			badCrc_reg   <= 1'b0;
		end else begin
			if (rxTick & ~crs)
				rxHunt_reg <= 16'h0;
			else if (rxSample)
				rxHunt_reg <= huntNext;
			if (sfdSeen) begin
				rxState_reg  <= RX_FRAME;
				rxDibIdx_reg <= 2'h0;
				rxCnt_reg    <= 16'h0;
				rxBad_reg    <= 1'b0;
				rxAccept_reg <= 1'b0;
			end else if (rxEnd) begin
				rxGood_reg   <= lenOk & crcOk & ~rxBad_reg;
				badLen_reg   <= ~lenOk;
				badCrc_reg   <= ~crcOk;
				flushCnt_reg <= keepFcs ? 3'(ADDR_LEN) : 3'(ADDR_LEN - FCS_LEN);
				rxState_reg  <= (rxAccept_reg & linkOn) ? RX_FLUSH : RX_HUNT;
			end else if (flushing) begin
				flushCnt_reg <= flushCnt_reg - 3'h1;
				if (flushLast)
					rxState_reg <= RX_HUNT;
			end else if (rxSample & (rxState_reg == RX_FRAME)) begin
				rxSh_reg     <= rxByteNow;
				rxDibIdx_reg <= rxDibIdx_reg + 2'h1;
				if (rxErr)
					rxBad_reg <= 1'b1;
				if (rxPush && rxCnt_reg != 16'hffff)
					rxCnt_reg <= rxCnt_reg + 16'h1;
				if (rxPush && atDecide)
					rxAccept_reg <= addrOk;
			end
		end
	end

	// Receive stream out
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rxBeatValid <= 1'b0;
			rxBeat      <= '0;
		end else begin
			rxBeatValid <= rxEmit | flushing;
			rxBeat.data <= dly[5];
			rxBeat.last <= flushLast;
			rxBeat.good <= flushLast & rxGood_reg;
		end
	end

	rmf_crc32 u_rxCrc (
		.core_clk (core_clk),
		.reset    (reset),
		.init     (sfdSeen),
		.enable   (rxPush),
		.dataByte (rxByteNow),
		.crc      (rxCrc)
	);

	AST_TX_ON_TICK: assert property (
		$changed(txDibitValid) |-> $past(txTick) || $past(!linkOn))
		else $error("transmit enable moved off a reference edge");
	AST_TX_IDLE_ZERO: assert property (
		!txDibitValid |-> txDibit == 2'h0)
		else $error("transmit dibit not zero while enable low");
	AST_SFD_AFTER_PRE: assert property (
		$rose(txState_reg == TX_SFD) |-> $past(preCnt_reg) == 4'(PREAMBLE_LEN))
		else $error("delimiter not after seven preamble bytes");
	AST_DATA_AFTER_SFD: assert property (
		$rose(txState_reg == TX_DATA) |-> $past(txState_reg) == TX_SFD)
		else $error("content did not follow delimiter");
	AST_PAD_MIN: assert property (
		$rose(txState_reg == TX_FCS) |-> txCnt_reg >= 11'(MIN_CONTENT_LEN))
		else $error("check sequence sent before minimum content");
	AST_RX_GOOD_LEN: assert property (
		rxBeatValid && rxBeat.good |-> !badLen_reg && !badCrc_reg)
		else $error("good frame flagged with bad length or CRC");
	AST_RX_ADDR: assert property (
		rxBeatValid |-> rxAccept_reg)
		else $error("byte delivered from unaccepted frame");
	AST_MGMT_OFF: assert property (
		linkOn [*2] |-> !mgmtPinsEnable)
		else $error("management pins enabled in reduced mode");
	AST_COLLISION: assert property (
		$rose(collision_reg) |-> $past(txActive) && $past(sfdSeen))
		else $error("collision flagged without overlap");
	AST_SLOW_SAMPLE: assert property (
		rxSample && !speed100 |-> divCnt_reg == 4'h0 ##1 !rxSample [*2])
		else $error("slow receive sampled off the tenth cycle");

endmodule : rmf_rmii_mac

// ### rmf_pkg.sv
package rmf_pkg;

	// Frame layout
	localparam logic [7:0]  PREAMBLE_BYTE   = 8'h55;
	localparam logic [7:0]  SFD_BYTE        = 8'h5d;
	localparam int          PREAMBLE_LEN    = 7;
	localparam int          ADDR_LEN        = 6;
	localparam int          FCS_LEN         = 4;
	localparam int          MIN_FRAME_LEN   = 64;
	localparam int          MIN_CONTENT_LEN = MIN_FRAME_LEN - FCS_LEN;
	localparam int          HDR_OVERHEAD    = 18;
	localparam logic [7:0]  PAD_BYTE        = 8'h00;
	localparam logic [7:0]  BCAST_BYTE      = 8'hff;

	// Link timing
	localparam int          SLOW_DIVIDE     = 10;
	localparam logic [3:0]  SLOW_DIV_LAST   = 4'(SLOW_DIVIDE - 1);

	// CRC-32
	localparam logic [31:0] CRC_INIT        = 32'hffffffff;
	localparam logic [31:0] CRC_POLY        = 32'hedb88320;
	localparam logic [31:0] CRC_RESIDUE     = 32'hdebb20e3;

	// Register offsets
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_MAC_LO     = 8'h04;
	localparam logic [7:0]  ADDR_MAC_HI     = 8'h08;
	localparam logic [7:0]  ADDR_MAX_LEN    = 8'h0c;
	localparam logic [7:0]  ADDR_STATUS     = 8'h10;

	// Control fields and reset values
	localparam int          CTRL_RMII       = 0;
	localparam int          CTRL_SPEED100   = 1;
	localparam int          CTRL_PROMISC    = 2;
	localparam int          CTRL_MCAST      = 3;
	localparam int          CTRL_BCAST      = 4;
	localparam int          CTRL_KEEP_FCS   = 5;
	localparam logic [5:0]  CTRL_RESET      = 6'h03;
	localparam logic [15:0] MAX_LEN_RESET   = 16'h05ee;
	localparam logic [31:0] MAC_LO_RESET    = 32'h00000000;
	localparam logic [15:0] MAC_HI_RESET    = 16'h0000;

	// Status fields
	localparam int          ST_COLLISION    = 0;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
		logic       err;
	} rmf_tx_beat_t;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
		logic       good;
	} rmf_rx_beat_t;

	typedef enum logic [5:0] {
		TX_IDLE = 6'h01,
		TX_PRE  = 6'h02,
		TX_SFD  = 6'h04,
		TX_DATA = 6'h08,
		TX_PAD  = 6'h10,
		TX_FCS  = 6'h20
	} rmf_tx_state_t;

	typedef enum logic [2:0] {
		RX_HUNT  = 3'h1,
		RX_FRAME = 3'h2,
		RX_FLUSH = 3'h4
	} rmf_rx_state_t;

endpackage : rmf_pkg

// ### rmf_crc32.sv
`timescale 1ns/1ps
module rmf_crc32 (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        init,
	input  wire logic        enable,
	input  wire logic [7:0]  dataByte,
	output logic      [31:0] crc
);
	import rmf_pkg::*;

	logic [31:0] crc_next;

	// Reflected byte-wise update, lsb first
	always_comb begin
		crc_next = crc;
		for (int i = 0; i < 8; i++) begin
			crc_next = (crc_next >> 1) ^ ((crc_next[0] ^ dataByte[i]) ? CRC_POLY : 32'h00000000);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset || init)
			crc <= CRC_INIT;
		else if (enable)
			crc <= crc_next;
	end

endmodule : rmf_crc32

// ### rmf_phy_model.sv
`timescale 1ns/1ps
module rmf_phy_model (
	output logic            linkRefClock,
	output logic            carrierAndRxValid,
	output logic      [1:0] rxDibit,
	output logic            rxSymbolError,
	input  wire logic [1:0] txDibit,
	input  wire logic       txDibitValid
);
	import rmf_pkg::*;
	logic [7:0] txBytes[$];
	logic [7:0] sh;
	logic [1:0] cnt;
	logic       busy;
	initial begin
		{carrierAndRxValid, rxDibit, rxSymbolError, cnt, busy} = '0;
		linkRefClock = 1'b0;
		#7;
		forever #160 linkRefClock = ~linkRefClock;
	end
	always @(posedge linkRefClock) begin
		if (txDibitValid === 1'b1) begin
			sh = {txDibit, sh[7:2]};
			if (cnt == 2'd3) txBytes.push_back(sh);
			cnt = cnt + 2'd1;
		end else cnt = 2'd0;
		if (!busy) rxDibit <= ~rxDibit;
	end
	task automatic send(input logic [7:0] q[$], input logic slow, input int errAt);
		logic [7:0] b;
		busy = 1'b1;
		for (int i = -8; i < q.size(); i++) begin
			b = i < -1 ? PREAMBLE_BYTE : i < 0 ? SFD_BYTE : q[i];
			for (int j = 0; j < 8; j += 2) repeat (slow ? SLOW_DIVIDE : 1) begin
				@(posedge linkRefClock);
				carrierAndRxValid <= 1'b1;
				rxDibit <= b[j +: 2];
				rxSymbolError <= i == errAt;
			end
		end
		@(posedge linkRefClock);
		{carrierAndRxValid, rxSymbolError} <= 2'b00;
		busy = 1'b0;
	endtask : send
endmodule : rmf_phy_model

// ### rmf_rmii_mac_tb.sv
`timescale 1ns/1ps
module rmf_rmii_mac_tb;
	import rmf_pkg::*;
	logic         core_clk, reset, psel, penable, pwrite, pready, pslverr, linkRefClock, e;
	logic         carrierAndRxValid, rxSymbolError, txDibitValid, mgmtPinsEnable;
	logic         txBeatValid, txBeatReady, rxBeatValid;
	logic [1:0]   rxDibit, txDibit;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, r;
	logic [47:0]  ourMac, dst;
	logic [7:0]   fr[$], ex[$];
	logic [5:0]   ctrlVal;
	logic [5:0]   modeCtrl[7] = '{6'h03, 6'h03, 6'h13, 6'h13, 6'h07, 6'h0b, 6'h23};
	int           modeDst[7] = '{0, 1, 1, 2, 2, 3, 0};
	int           mismatches, samples_checked, maxLen, k;
	integer       seed;
	rmf_tx_beat_t txBeat;
	rmf_rx_beat_t rxBeat, rxq[$];

	rmf_rmii_mac i_dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .linkRefClock, .carrierAndRxValid, .rxDibit, .rxSymbolError, .txDibit, .txDibitValid,
		.mgmtPinsEnable, .txBeat, .txBeatValid, .txBeatReady, .rxBeat, .rxBeatValid);
	rmf_phy_model i_phy (.linkRefClock, .carrierAndRxValid, .rxDibit, .rxSymbolError, .txDibit,
		.txDibitValid);

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (rxBeatValid === 1'b1) rxq.push_back(rxBeat);

	task automatic check(input string w, input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", w, x, s);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		limit(n, 50);
	endtask : apb
	task automatic limit(input int n, input int m);
		if (n >= m) begin
			mismatches++;
			print_verdict();
		end
	endtask : limit
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		if (a == ADDR_CTRL) ctrlVal = d[5:0];
		if (a == ADDR_MAX_LEN) maxLen = int'(d[15:0]);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string w);
		apb(1'b0, a, 32'h0);
		check(w, r, x);
	endtask : rd
	task automatic build(input logic [47:0] d, input logic [47:0] s, input int n, input logic pad);
		logic [31:0] c;
		fr = {};
		for (int i = 0; i < 12; i++) fr.push_back(i < 6 ? d[8*i +: 8] : s[8*i-48 +: 8]);
		fr.push_back(8'h00);
		fr.push_back(8'(n));
		repeat (n) fr.push_back(8'($random(seed)));
		while (pad && fr.size() < MIN_CONTENT_LEN) fr.push_back(PAD_BYTE);
		c = CRC_INIT;
		foreach (fr[i]) begin
			c = c ^ {24'h0, fr[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		for (int i = 0; i < 4; i++) fr.push_back(~c[8*i +: 8]);
	endtask : build
	task automatic txFrame(input int n, input logic bad);
		build({16'($random(seed)), 32'($random(seed))}, ourMac, n, 1'b1);
		ex = {};
		repeat (PREAMBLE_LEN) ex.push_back(PREAMBLE_BYTE);
		ex.push_back(SFD_BYTE);
		foreach (fr[i]) ex.push_back(bad && i >= fr.size() - FCS_LEN ? ~fr[i] : fr[i]);
		@(posedge core_clk);
		for (int i = 0; i < 14 + n; i++) begin
			if (i < 6 || i > 11) begin
				txBeat <= '{fr[i], i == 13 + n, bad && i == 13 + n};
				txBeatValid <= 1'b1;
				k = 0;
				do begin
					@(posedge core_clk);
					k++;
				end while (txBeatReady !== 1'b1 && k < 2000);
				limit(k, 2000);
			end
		end
		txBeatValid <= 1'b0;
		k = 0;
		while ((i_phy.txBytes.size() < ex.size() || txDibitValid !== 1'b0) && k < 9000) begin
			@(posedge core_clk);
			k++;
		end
		limit(k, 9000);
		check("tx length", 32'(i_phy.txBytes.size()), 32'(ex.size()));
		foreach (ex[i]) check("tx byte", 32'(i_phy.txBytes[i]), 32'(ex[i]));
		check("tx idle dibit", 32'(txDibit), 32'h0);
		i_phy.txBytes = {};
	endtask : txFrame
	task automatic rxFrame(input int dsel, input int n, input logic pad, input logic slow, input int errAt,
		input logic flip);
		logic acc, good;
		int   cnt;
		dst = dsel == 0 ? ourMac : dsel == 1 ? '1 : {40'h0033221100, 7'h0, dsel == 3};
		build(dst, 48'h001122334402, n, pad);
		if (flip) fr[20] = ~fr[20];
		acc = dst === ourMac || (dsel == 1 && ctrlVal[CTRL_BCAST]) || ctrlVal[CTRL_PROMISC]
			|| (dst[0] && ctrlVal[CTRL_MCAST]);
		good = fr.size() >= MIN_FRAME_LEN && fr.size() <= maxLen && errAt < 0 && !flip;
		cnt = acc ? fr.size() - (ctrlVal[CTRL_KEEP_FCS] ? 0 : FCS_LEN) : 0;
		rxq = {};
		i_phy.send(fr, slow, errAt);
		k = 0;
		while (rxq.size() < cnt && k < 300) begin
			@(posedge core_clk);
			k++;
		end
		repeat (40) @(posedge core_clk);
		limit(k, 300);
		check("rx count", 32'(rxq.size()), 32'(cnt));
		foreach (rxq[i]) check("rx byte", 32'({rxq[i].data, rxq[i].last}), 32'({fr[i], i == cnt - 1}));
		if (cnt > 0) check("rx good", 32'(rxq[cnt - 1].good), 32'(good));
	endtask : rxFrame
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (95000) @(posedge core_clk);
		mismatches++;
		print_verdict();
	end
	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, txBeat, txBeatValid} = '0;
		seed = 32198;
		ourMac = 48'h5a4b3c2d1e0c;
		ctrlVal = CTRL_RESET;
		maxLen = int'(MAX_LEN_RESET);
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		rd(ADDR_CTRL, 32'(CTRL_RESET), "ctrl");
		rd(ADDR_MAX_LEN, 32'(MAX_LEN_RESET), "max length");
		rd(8'h14, 32'h0, "unmapped data");
		check("unmapped error", 32'(e), 32'h1);
		check("mgmt pins", 32'(mgmtPinsEnable), 32'h0);
		wr(ADDR_MAC_LO, ourMac[31:0]);
		wr(ADDR_MAC_HI, 32'(ourMac[47:32]));
		rd(ADDR_MAC_HI, 32'(ourMac[47:32]), "mac high");
		$display("test registers done");
		txFrame(1, 1'b0);
		txFrame(46, 1'b1);
		txFrame(20 + ($random(seed) & 31), 1'b0);
		$display("test transmit done");
		fork
			txFrame(1, 1'b0);
			begin
				repeat (100) @(posedge core_clk);
				i_phy.send(fr, 1'b0, -1);
			end
		join
		repeat (40) @(posedge core_clk);
		rd(ADDR_STATUS, 32'h1, "collision");
		wr(ADDR_STATUS, 32'h1);
		rd(ADDR_STATUS, 32'h0, "status cleared");
		$display("test collision done");
		for (int i = 0; i < 7; i++) begin
			wr(ADDR_CTRL, 32'(modeCtrl[i]));
			rxFrame(modeDst[i], 1 + ($random(seed) & 31), 1'b1, 1'b0, -1, 1'b0);
		end
		$display("test address filter done");
		wr(ADDR_CTRL, 32'(CTRL_RESET));
		rxFrame(0, 30, 1'b1, 1'b0, -1, 1'b1);
		rxFrame(0, 30, 1'b1, 1'b0, 20, 1'b0);
		rxFrame(0, 10, 1'b0, 1'b0, -1, 1'b0);
		wr(ADDR_MAX_LEN, 32'd64);
		rxFrame(0, 46, 1'b1, 1'b0, -1, 1'b0);
		rxFrame(0, 47, 1'b1, 1'b0, -1, 1'b0);
		wr(ADDR_MAX_LEN, 32'(MAX_LEN_RESET));
		$display("test receive errors done");
		wr(ADDR_CTRL, 32'h01);
		rxFrame(0, 5, 1'b1, 1'b1, -1, 1'b0);
		$display("test slow link done");
		wr(ADDR_CTRL, 32'h00);
		repeat (2) @(posedge core_clk);
		check("mgmt pins", 32'(mgmtPinsEnable), 32'h1);
		$display("test interface select done");
		print_verdict();
	end
endmodule : rmf_rmii_mac_tb
